// File: hdl/tap_consts.vh
// How it works
// - one TDO pin, muxed between own controller output and core debug output
// - core debug instructions route core TDO in Shift-DR; own instructions and Shift-IR route own TDO
// - instruction chain is four bits and holds the current instruction
// - bypass, idcode, sample/preload, extest, intest, access-port, debug-port, abort
// - state advances only on sampled TMS at rising TCK, on TRST and on power-on reset
// - TAP state decides capture, shift and update of the selected chain
// - TAP state decides whether instruction or data chain is accessed
// - held instruction selects which data chain is used
// - extest and intest act on held data without their own chain activity
// - unimplemented codes decode as bypass
// - serial data enters on TDI and leaves on TDO
// - TRST low resets TAP and test logic without a TCK edge
// - while TRST low, TAP stays in Test-Logic-Reset
// - entering Test-Logic-Reset loads IDCODE into the instruction register
// - after reset the pins serve the test function, select bit set
// - moving pins to general I/O needs unlock and commit first
// - five TMS-high rising edges reach Test-Logic-Reset from any state
// - power-on reset also forces Test-Logic-Reset
// - TDO not driven unless shifting data out
// - shifted data reaches parallel register only in update state
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH

`define IR_W            4
`define DR_W            32
`define BSR_W           8
`define INSTR_EXTEST    4'h0
`define INSTR_INTEST    4'h1
`define INSTR_SAMPLE    4'h2
`define INSTR_ABORT     4'h8
`define INSTR_DEBUG_PORT_ACCESS_INSTR     4'ha
`define INSTR_ACCESS_PORT_ACCESS_INSTR     4'hb
`define INSTR_IDCODE    4'he
`define INSTR_BYPASS    4'hf
`define IR_CAPTURE_VAL  4'h1
// arbitrary neutral identification value
`define IDCODE_VAL      32'h1000_0001
`define UNLOCK_KEY      32'h5a5a_c3c3

`define ST_RESET        4'h0
`define ST_IDLE         4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SH_DR        4'h4
`define ST_EX1_DR       4'h5
`define ST_PAU_DR       4'h6
`define ST_EX2_DR       4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'ha
`define ST_SH_IR        4'hb
`define ST_EX1_IR       4'hc
`define ST_PAU_IR       4'hd
`define ST_EX2_IR       4'he
`define ST_UPD_IR       4'hf

`endif

// File: hdl/pin_sync.v
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// pin in, synchronised out
	input  wire din,
	output reg  dout
);
	reg stage;

	always @(posedge clk) begin
		if (!rst_n) begin
			stage <= 1'b0;
			dout  <= 1'b0;
		end else begin
			stage <= din;
			dout  <= stage;
		end
	end
endmodule
`default_nettype wire

// File: hdl/jtag_tap.v
`timescale 1ns/10ps
`default_nettype none
`include "tap_consts.vh"
module jtag_tap (
	// clock and power-on reset
	input  wire        REF_CLK,
	input  wire        RESETN,
	// test port pins
	input  wire        TCK,
	input  wire        TMS,
	input  wire        TDI,
	input  wire        TRST_N,
	output reg         TDO,
	output reg         TDO_OE,
	// core debug TAP
	input  wire        CORE_TDO,
	output reg         CORE_SEL,
	// boundary cells
	input  wire [7:0]  PIN_IN,
	output reg  [7:0]  BSR_OUT,
	output reg         EXTEST_ACTIVE,
	output reg         INTEST_ACTIVE,
	// pin function control
	input  wire        ALT_WR,
	input  wire        ALT_WDATA,
	input  wire        LOCK_WR,
	input  wire [31:0] LOCK_WDATA,
	input  wire        COMMIT_WR,
	input  wire        COMMIT_WDATA,
	output reg         ALT_FUNCTION_SELECT_BIT,
	output reg  [3:0]  TAP_STATE
);
	////////////////////////////////////////////////////////////////////////
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire trst_s;
	wire ctdo_s;
	reg  tck_d;
	wire tck_rise;
	wire tck_fall;
	wire trst_now;

	pin_sync u_tck  (.clk(REF_CLK), .rst_n(RESETN), .din(TCK),      .dout(tck_s));
	pin_sync u_tms  (.clk(REF_CLK), .rst_n(RESETN), .din(TMS),      .dout(tms_s));
	pin_sync u_tdi  (.clk(REF_CLK), .rst_n(RESETN), .din(TDI),      .dout(tdi_s));
	pin_sync u_trst (.clk(REF_CLK), .rst_n(RESETN), .din(TRST_N),   .dout(trst_s));
	pin_sync u_ctdo (.clk(REF_CLK), .rst_n(RESETN), .din(CORE_TDO), .dout(ctdo_s));

	always @(posedge REF_CLK) begin
		if (!RESETN)
			tck_d <= 1'b0;
		else
			tck_d <= tck_s;
	end

	assign tck_rise = tck_s & ~tck_d;
	assign tck_fall = ~tck_s & tck_d;
	// trst acts on its own, no tck edge needed
	assign trst_now = ~trst_s;

	////////////////////////////////////////////////////////////////////////
	reg [3:0] state;
	reg [3:0] next_state;

	always @* begin
		next_state = state;
		case (state)
		`ST_RESET:  next_state = tms_s ? `ST_RESET  : `ST_IDLE;
		`ST_IDLE:   next_state = tms_s ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_DR: next_state = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
		`ST_CAP_DR: next_state = tms_s ? `ST_EX1_DR : `ST_SH_DR;
		`ST_SH_DR:  next_state = tms_s ? `ST_EX1_DR : `ST_SH_DR;
		`ST_EX1_DR: next_state = tms_s ? `ST_UPD_DR : `ST_PAU_DR;
		`ST_PAU_DR: next_state = tms_s ? `ST_EX2_DR : `ST_PAU_DR;
		`ST_EX2_DR: next_state = tms_s ? `ST_UPD_DR : `ST_SH_DR;
		`ST_UPD_DR: next_state = tms_s ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_IR: next_state = tms_s ? `ST_RESET  : `ST_CAP_IR;
		`ST_CAP_IR: next_state = tms_s ? `ST_EX1_IR : `ST_SH_IR;
		`ST_SH_IR:  next_state = tms_s ? `ST_EX1_IR : `ST_SH_IR;
		`ST_EX1_IR: next_state = tms_s ? `ST_UPD_IR : `ST_PAU_IR;
		`ST_PAU_IR: next_state = tms_s ? `ST_EX2_IR : `ST_PAU_IR;
		`ST_EX2_IR: next_state = tms_s ? `ST_UPD_IR : `ST_SH_IR;
		`ST_UPD_IR: next_state = tms_s ? `ST_SEL_DR : `ST_IDLE;
		default:    next_state = `ST_RESET;
		endcase
	end

	always @(posedge REF_CLK) begin
		if (!RESETN)
			state <= `ST_RESET;
		else if (trst_now)
			state <= `ST_RESET;
		else if (tck_rise)
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// instruction chain and decode
	reg  [3:0]  ir_shift;
	reg  [3:0]  ir;
	reg  [3:0]  instr;
	wire        in_reset;

	assign in_reset = (state == `ST_RESET);

	always @* begin
		case (ir)
		`INSTR_EXTEST, `INSTR_INTEST, `INSTR_SAMPLE, `INSTR_ABORT,
		`INSTR_DEBUG_PORT_ACCESS_INSTR, `INSTR_ACCESS_PORT_ACCESS_INSTR, `INSTR_IDCODE:
			instr = ir;
		default:
			instr = `INSTR_BYPASS;
		endcase
	end

	wire core_instr = (instr == `INSTR_ABORT) | (instr == `INSTR_DEBUG_PORT_ACCESS_INSTR) |
		(instr == `INSTR_ACCESS_PORT_ACCESS_INSTR);

	always @(posedge REF_CLK) begin
		if (!RESETN || trst_now || in_reset) begin
			ir_shift <= `IR_CAPTURE_VAL;
			ir       <= `INSTR_IDCODE;
		end else if (tck_rise) begin
			case (state)
			`ST_CAP_IR: ir_shift <= `IR_CAPTURE_VAL;
			`ST_SH_IR:  ir_shift <= {tdi_s, ir_shift[3:1]};
			`ST_UPD_IR: ir       <= ir_shift;
			default:    ir_shift <= ir_shift;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data chains: bypass, idcode, boundary
	reg         byp;
	reg  [31:0] id_shift;
	reg  [7:0]  bsr_shift;
	wire        dr_cap = tck_rise & (state == `ST_CAP_DR);
	wire        dr_sh  = tck_rise & (state == `ST_SH_DR);
	wire        dr_upd = tck_rise & (state == `ST_UPD_DR);

	always @(posedge REF_CLK) begin
		if (!RESETN || trst_now) begin
			byp       <= 1'b0;
			id_shift  <= 32'h0000_0000;
			bsr_shift <= 8'h00;
			BSR_OUT   <= 8'h00;
		end else begin
			if (instr == `INSTR_BYPASS) begin
				if (dr_cap)
					byp <= 1'b0;
				else if (dr_sh)
					byp <= tdi_s;
			end
			if (instr == `INSTR_IDCODE) begin
				if (dr_cap)
					id_shift <= `IDCODE_VAL;
				else if (dr_sh)
					id_shift <= {tdi_s, id_shift[31:1]};
			end
			// extest/intest never touch chains here
			if (instr == `INSTR_SAMPLE) begin
				if (dr_cap)
					bsr_shift <= PIN_IN;
				else if (dr_sh)
					bsr_shift <= {tdi_s, bsr_shift[7:1]};
				else if (dr_upd)
					BSR_OUT <= bsr_shift;
			end
		end
	end

	always @(posedge REF_CLK) begin
		if (!RESETN || trst_now) begin
			EXTEST_ACTIVE <= 1'b0;
			INTEST_ACTIVE <= 1'b0;
		end else begin
			EXTEST_ACTIVE <= (instr == `INSTR_EXTEST);
			INTEST_ACTIVE <= (instr == `INSTR_INTEST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// own tdo and output mux, changes on falling tck
	reg own_tdo;

	always @* begin
		case (instr)
		`INSTR_IDCODE:                               own_tdo = id_shift[0];
		`INSTR_SAMPLE, `INSTR_EXTEST, `INSTR_INTEST: own_tdo = bsr_shift[0];
		default:                                     own_tdo = byp;
		endcase
		if (state == `ST_SH_IR)
			own_tdo = ir_shift[0];
	end

	wire shifting = (state == `ST_SH_IR) | (state == `ST_SH_DR);

	always @(posedge REF_CLK) begin
		if (!RESETN || trst_now) begin
			TDO      <= 1'b0;
			TDO_OE   <= 1'b0;
			CORE_SEL <= 1'b0;
		end else if (tck_fall) begin
			CORE_SEL <= core_instr;
			TDO_OE   <= shifting;
			if (core_instr && state == `ST_SH_DR)
				TDO <= ctdo_s;
			else
				TDO <= own_tdo;
		end
	end

	always @(posedge REF_CLK) begin
		if (!RESETN)
			TAP_STATE <= `ST_RESET;
		else
			TAP_STATE <= state;
	end

	////////////////////////////////////////////////////////////////////////
	// pin function with commit protection
	reg unlocked;
	reg commit;

	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			unlocked                <= 1'b0;
			commit                  <= 1'b0;
			ALT_FUNCTION_SELECT_BIT <= 1'b1;
		end else begin
			if (LOCK_WR)
				unlocked <= (LOCK_WDATA == `UNLOCK_KEY);
			if (COMMIT_WR && unlocked)
				commit <= COMMIT_WDATA;
			if (ALT_WR && unlocked && commit)
				ALT_FUNCTION_SELECT_BIT <= ALT_WDATA;
		end
	end
endmodule
`default_nettype wire

// File: sim/tap_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "tap_consts.vh"
module tap_checker (
	// clock and reset
	input wire       REF_CLK,
	input wire       RESETN,
	// test pins
	input wire       TCK,
	input wire       TRST_N,
	input wire       TDO,
	input wire       TDO_OE,
	// decoded outputs
	input wire       CORE_SEL,
	input wire [7:0] BSR_OUT,
	input wire       ALT_WR,
	input wire       ALT_FUNCTION_SELECT_BIT,
	input wire [3:0] TAP_STATE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	trst_state_a: assert property (!TRST_N [*5] |-> TAP_STATE == `ST_RESET)
		else $error("state not reset under trst");
	trst_quiet_a: assert property (!TRST_N [*4] |-> !TDO_OE && !CORE_SEL)
		else $error("outputs active under trst");
	oe_shift_only_a: assert property (TDO_OE && TRST_N |-> TAP_STATE inside
		{`ST_SH_DR, `ST_EX1_DR, `ST_SH_IR, `ST_EX1_IR}) else $error("tdo driven off shift");
	state_needs_tck_a: assert property ((TRST_N && !TCK) [*8] |=> $stable(TAP_STATE))
		else $error("state moved without tck");
	tdo_on_fall_a: assert property ((TCK && TRST_N) [*6] |=> $stable(TDO) && $stable(TDO_OE))
		else $error("tdo moved while tck high");
	alt_locked_a: assert property ($changed(ALT_FUNCTION_SELECT_BIT) |-> $past(ALT_WR))
		else $error("select bit moved without write");
	alt_reset_a: assert property ($rose(RESETN) |-> ALT_FUNCTION_SELECT_BIT)
		else $error("select bit clear after reset");
	bsr_update_a: assert property ($changed(BSR_OUT) |-> TAP_STATE inside
		{`ST_UPD_DR, `ST_RESET}) else $error("boundary out changed off update");
	core_sel_a: assert property ($changed(CORE_SEL) && TRST_N |-> TAP_STATE inside
		{`ST_UPD_IR, `ST_IDLE, `ST_SEL_DR, `ST_RESET})
		else $error("core select changed off update");
endmodule
bind jtag_tap tap_checker u_chk (.*);
`default_nettype wire

// File: sim/jtag_probe.sv
`timescale 1ns/10ps
`default_nettype none
module jtag_probe (
	// system clock
	input wire logic REF_CLK,
	// from the device
	input wire logic TDO,
	input wire logic TDO_OE,
	// to the device
	output var logic TCK,
	output var logic TMS,
	output var logic TDI,
	output var logic TRST_N
);
	initial begin
		{TCK, TMS, TDI, TRST_N} = 4'b0111;
	end
	task trst(input logic v);
		TRST_N = v;
	endtask
	// tck stands low between steps; released tdo reads as pulled up
	task step(input logic tms, input logic tdi, output logic tdo);
		TMS = tms;
		TDI = tdi;
		repeat (6) @(negedge REF_CLK);
		tdo = TDO_OE ? TDO : 1'b1;
		TCK = 1'b1;
		repeat (6) @(negedge REF_CLK);
		TCK = 1'b0;
	endtask
	task scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
		logic t;
		step(1'b1, 1'b1, t);
		if (ir)
			step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
		step(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], t);
			dout = {t, dout[31:1]};
		end
		step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
		dout = dout >> (32 - n);
	endtask
endmodule
`default_nettype wire

// File: sim/jtag_tap_with_tdo_mux_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "tap_consts.vh"
module jtag_tap_with_tdo_mux_test;
	logic        REF_CLK, RESETN, TCK, TMS, TDI, TRST_N, TDO, TDO_OE, CORE_TDO, CORE_SEL;
	logic        EXTEST_ACTIVE, INTEST_ACTIVE, ALT_WR, ALT_WDATA, LOCK_WR, COMMIT_WR;
	logic        COMMIT_WDATA, ALT_FUNCTION_SELECT_BIT, t;
	logic [7:0]  PIN_IN, BSR_OUT;
	logic [3:0]  TAP_STATE;
	logic [31:0] LOCK_WDATA, d;
	int          n_fail, samples_checked;
	jtag_tap uut (.*);
	jtag_probe probe (.*);
	initial begin
		REF_CLK = 1'b0;
		forever #2 REF_CLK = ~REF_CLK;
	end
	////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task ir(input logic [3:0] c);
		probe.scan(1'b1, {28'h0, c}, 4, d);
		chk(d, {28'h0, `IR_CAPTURE_VAL}, "ir capture");
	endtask
	task dr(input logic [31:0] din, input int n, input logic [31:0] exp, input string m);
		probe.scan(1'b0, din, n, d);
		chk(d, exp, m);
	endtask
	task wr(input int k, input logic [31:0] v);
		{ALT_WDATA, COMMIT_WDATA, LOCK_WDATA} = {v[0], v[0], v};
		{ALT_WR, LOCK_WR, COMMIT_WR} = 3'b100 >> k;
		@(negedge REF_CLK);
		{ALT_WR, LOCK_WR, COMMIT_WR} = 3'b000;
		repeat (2) @(negedge REF_CLK);
	endtask
	task to_shift_dr;
		probe.step(1'b1, 1'b1, t);
		repeat (2) probe.step(1'b0, 1'b1, t);
	endtask
	////////////////////////////////////////
	task t_trst;
		ir(4'hf);
		to_shift_dr();
		probe.trst(1'b0);
		repeat (5) @(negedge REF_CLK);
		chk(32'(TAP_STATE), `ST_RESET, "trst state");
		chk(32'({TDO_OE, CORE_SEL}), 0, "trst outputs");
		probe.trst(1'b1);
		repeat (4) @(negedge REF_CLK);
		probe.step(1'b0, 1'b1, t);
		dr(0, 32, `IDCODE_VAL, "idcode after trst");
		$display("test trst done");
	endtask
	task t_tms5;
		ir(`INSTR_SAMPLE);
		to_shift_dr();
		repeat (5) probe.step(1'b1, 1'b1, t);
		chk(32'(TAP_STATE), `ST_RESET, "tms reset");
		probe.step(1'b0, 1'b1, t);
		dr(0, 32, `IDCODE_VAL, "idcode after tms");
		$display("test tms done");
	endtask
	task t_bypass;
		for (int c = 0; c < 16; c++) begin
			if (c inside {0, 1, 2, 8, 10, 11, 14})
				continue;
			ir(4'(c));
			dr(32'ha5, 8, 32'h4a, "bypass path");
			chk(32'(CORE_SEL), 0, "own tdo");
		end
		$display("test bypass done");
	endtask
	task t_core;
		logic [3:0] codes [3] = '{`INSTR_ABORT, `INSTR_DEBUG_PORT_ACCESS_INSTR, `INSTR_ACCESS_PORT_ACCESS_INSTR};
		foreach (codes[i]) begin
			CORE_TDO = codes[i][0];
			ir(codes[i]);
			repeat (4) @(negedge REF_CLK);
			chk(32'(CORE_SEL), 1, "core select");
			dr(0, 4, codes[i][0] ? 32'hf : 32'h0, "core tdo");
		end
		CORE_TDO = 1'b0;
		$display("test core done");
	endtask
	task t_boundary;
		PIN_IN = 8'h3c;
		ir(`INSTR_SAMPLE);
		dr(32'h96, 8, 32'h3c, "sample capture");
		chk(32'(BSR_OUT), 32'h96, "update");
		ir(`INSTR_EXTEST);
		chk(32'({EXTEST_ACTIVE, BSR_OUT}), 32'h196, "extest");
		ir(`INSTR_INTEST);
		chk(32'({INTEST_ACTIVE, BSR_OUT}), 32'h196, "intest");
		$display("test boundary done");
	endtask
	task t_alt;
		chk(32'(ALT_FUNCTION_SELECT_BIT), 1, "default test function");
		wr(0, 0);
		wr(1, 32'h0);
		wr(2, 1);
		wr(0, 0);
		chk(32'(ALT_FUNCTION_SELECT_BIT), 1, "locked write");
		wr(1, `UNLOCK_KEY);
		wr(2, 1);
		wr(0, 0);
		chk(32'(ALT_FUNCTION_SELECT_BIT), 0, "committed write");
		$display("test alt done");
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		{RESETN, CORE_TDO, PIN_IN, ALT_WR, ALT_WDATA, LOCK_WR} = '0;
		{LOCK_WDATA, COMMIT_WR, COMMIT_WDATA} = '0;
		repeat (12) @(negedge REF_CLK);
		RESETN = 1'b1;
		repeat (4) @(negedge REF_CLK);
		// scans start from run-test/idle
		probe.step(1'b0, 1'b1, t);
		t_trst();
		t_tms5();
		t_bypass();
		t_core();
		t_boundary();
		t_alt();
		end_of_test();
	end
	initial begin
		#200us;
		n_fail++;
		end_of_test();
	end
endmodule
`default_nettype wire
